/* File: hw/pse_mode_pkg.sv */
// constants and types shared by the channel mode control block
// Summary of operation
// R1 - one-byte read-only address status register at command code 0x11
// R2 - status bits 6..3 mirror the four address strap pins, highest first
// R3 - status bit 2 is the fixed half select: 0 channels 1-4, 1 channels 5-8
// R4 - configuration B forces the half select bit to read 0
// R5 - answer at 01 + straps + half bit, and at broadcast 1111111
// R6 - read/write mode register at command code 0x12, reset to zero
// R7 - two mode bits per channel, channel 4 on top; 00 off 01 manual 10 semi 11 auto
// R8 - both channels of a port share a mode, else turn-on commands ignored
// R9 - off channel stays unpowered with no detection or classification
// R10 - off entry clears channel events, faults and four-pair cut flags
// R11 - off entry sets channel two-pair policing byte to all ones
// R12 - off entry sets the port four-pair policing byte to all ones
// R13 - off entry clears channel voltage, current, resistance and autoclass readings
// R14 - off entry clears requested, detected, assigned and previous class fields
// R15 - off entry clears power status, enables, check bits and foldback settings
// R16 - all off-mode clearing completes within 5 ms of the mode change
// R17 - off-mode clearing touches only the channel or port entering off; port clear here fires when either channel of the port enters off
// R18 - power good or enable falling through off entry posts change events
// R19 - leaving semiauto for manual or off aborts a running cooldown
// R20 - reserved status bits read zero; writes to the status register ignored
// R21 - power enable status is cleared whenever the channel turns off
package pse_mode_pkg;

   localparam int          CHANNELS          = 4;
   localparam int          PORTS             = 2;
   localparam logic [7:0]  CMD_ADDR_STATUS   = 8'h11;
   localparam logic [7:0]  CMD_CHANNEL_MODE  = 8'h12;
   localparam logic [7:0]  MODE_RESET        = 8'h00;
   localparam logic [7:0]  POLICING_CLEARED  = 8'hff;
   localparam logic [1:0]  MODE_OFF          = 2'h0;
   localparam logic [1:0]  MODE_MANUAL       = 2'h1;
   localparam logic [1:0]  MODE_SEMIAUTO     = 2'h2;
   localparam logic [1:0]  MODE_AUTO         = 2'h3;
   localparam logic [1:0]  ADDR_PREFIX       = 2'h1;
   localparam logic [6:0]  BROADCAST_ADDR    = 7'h7f;
   localparam int          STATUS_STRAP_LSB  = 3;
   localparam int          STATUS_HALF_BIT   = 2;
   localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;
   localparam int          SYS_CLK_HZ        = 25000000;
   localparam int          OFF_CLEAR_MAX_MS  = 5;
   localparam int          OFF_CLEAR_MAX_CYCLES = OFF_CLEAR_MAX_MS * (SYS_CLK_HZ / 1000);

   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_ADDR      = 9'h002,
      ST_ADDR_ACK  = 9'h004,
      ST_CMD       = 9'h008,
      ST_CMD_ACK   = 9'h010,
      ST_WDATA     = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA     = 9'h080,
      ST_RDATA_ACK = 9'h100
   } serial_state_type;

   // pick one channel's mode pair out of the mode byte
   function automatic logic [1:0] field_of(input logic [7:0] modes, input int ch);
      field_of = modes[2*ch +: 2];
   endfunction : field_of

endpackage : pse_mode_pkg

/* File: hw/level_sync.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
module level_sync
   import pse_mode_pkg::*;
#(
   parameter int WIDTH = 6
)
(
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_level,
   output logic      [WIDTH-1:0] sync_level
);

   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r     <= '0;
         sync_level <= '0;
      end
      else
      begin
         meta_r     <= pin_level;
         sync_level <= meta_r;
      end
   end

endmodule : level_sync

/* File: hw/off_entry_watch.sv */
// per-channel watch for mode changes into off and out of semiauto
`timescale 1ns/10ps
module off_entry_watch
   import pse_mode_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] mode_field,
   input  wire logic       power_good,
   input  wire logic       power_enabled,
   output logic            off_clear,
   output logic            pg_event,
   output logic            pe_event,
   output logic            cooldown_abort
);

   logic [1:0] prev_mode_r;
   logic       entry;
   logic       leave_semi;

   assign entry      = (prev_mode_r != MODE_OFF) && (mode_field == MODE_OFF); // R10
   assign leave_semi = (prev_mode_r == MODE_SEMIAUTO) &&
                       ((mode_field == MODE_MANUAL) || (mode_field == MODE_OFF));

   // previous mode, reset matches the off reset value
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_mode_r <= MODE_OFF;
      else
         prev_mode_r <= mode_field;
   end

   // one-cycle strobes toward the channel state holders
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         off_clear      <= 1'b0;
         pg_event       <= 1'b0;
         pe_event       <= 1'b0;
         cooldown_abort <= 1'b0;
      end
      else
      begin
         off_clear      <= entry;                  // R10 R11 R13 R14 R15 R21
         pg_event       <= entry & power_good;     // R18
         pe_event       <= entry & power_enabled;  // R18
         cooldown_abort <= leave_semi;             // R19
      end
   end

   property p_entry_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      ($past(mode_field) != MODE_OFF) && (mode_field == MODE_OFF) |=> off_clear;
   endproperty
   a_entry_clear: assert property (p_entry_clear) // R10
      else $error("off entry did not raise the clear strobe");

   property p_clear_only_off;
      @(posedge sys_clk) disable iff (!rst_n)
      off_clear |-> ($past(mode_field) == MODE_OFF) && ($past(prev_mode_r) != MODE_OFF);
   endproperty
   a_clear_only_off: assert property (p_clear_only_off) // R17
      else $error("clear strobe without off entry");

   property p_pg_event;
      @(posedge sys_clk) disable iff (!rst_n)
      pg_event |-> off_clear && $past(power_good);
   endproperty
   a_pg_event: assert property (p_pg_event) // R18
      else $error("power good change event without cause");

   property p_cooldown;
      @(posedge sys_clk) disable iff (!rst_n)
      (prev_mode_r == MODE_SEMIAUTO) && (mode_field == MODE_MANUAL) |=> cooldown_abort;
   endproperty
   a_cooldown: assert property (p_cooldown) // R19
      else $error("cooldown not aborted on semiauto exit");

endmodule : off_entry_watch

/* File: hw/pse_channel_mode_control.sv */
// serial management slave with address status and channel mode registers
`timescale 1ns/10ps
module pse_channel_mode_control
   import pse_mode_pkg::*;
#(
   parameter int OFF_CLEAR_LIMIT = OFF_CLEAR_MAX_CYCLES
)
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       address_strap_pin_3,
   input  wire logic       address_strap_pin_2,
   input  wire logic       address_strap_pin_1,
   input  wire logic       address_strap_pin_0,
   input  wire logic       half_select_address_bit,
   input  wire logic       config_b_select,
   input  wire logic [3:0] detect_request,
   input  wire logic [3:0] classify_request,
   input  wire logic [3:0] power_on_command,
   input  wire logic [3:0] power_good_status,
   input  wire logic [3:0] power_enabled_status,
   output logic      [7:0] channel_mode_select,
   output logic      [3:0] detect_grant,
   output logic      [3:0] classify_grant,
   output logic      [3:0] power_on_grant,
   output logic      [1:0] turn_on_blocked,
   output logic      [3:0] channel_off_clear,
   output logic      [1:0] port_off_clear,
   output logic      [3:0] power_good_change_event,
   output logic      [3:0] power_enable_change_event,
   output logic      [3:0] cooldown_abort
);

   logic [5:0]       pins_s;
   logic             scl_s;
   logic             sda_s;
   logic [3:0]       strap_address_bits;
   logic             scl_d_r;
   logic             sda_d_r;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_seen;
   logic             stop_seen;
   logic             byte_done;
   serial_state_type state_r;
   serial_state_type state_nxt;
   logic [3:0]       bit_cnt_r;
   logic [7:0]       shift_r;
   logic [7:0]       tx_r;
   logic [7:0]       cmd_r;
   logic             rw_r;
   logic             mack_r;
   logic             sda_oe_r;
   logic [6:0]       own_addr;
   logic             addr_hit;
   logic             half_bit;
   logic [7:0]       status_byte;
   logic [7:0]       read_byte;
   logic             mode_wr;
   logic [7:0]       mode_r;
   logic [3:0]       chan_off;
   logic [3:0]       off_going;
   logic [1:0]       mismatch;

   // scl, sda and the straps come from pins
   level_sync #(
      .WIDTH (6)
   ) u_pin_sync (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .pin_level  ({scl_in, sda_in, address_strap_pin_3, address_strap_pin_2,
                    address_strap_pin_1, address_strap_pin_0}),
      .sync_level (pins_s)
   );

   assign scl_s              = pins_s[5];
   assign sda_s              = pins_s[4];
   assign strap_address_bits = pins_s[3:0];

   // fixed half select, forced low in configuration B
   assign half_bit = config_b_select ? 1'b0 : half_select_address_bit; // R4 R3

   // status byte assembly, reserved bits stay zero
   always_comb
   begin
      status_byte = 8'h00; // R20
      status_byte[STATUS_STRAP_LSB +: 4] = strap_address_bits; // R2
      status_byte[STATUS_HALF_BIT] = half_bit; // R3
   end

   // own address and broadcast match
   assign own_addr = {ADDR_PREFIX, strap_address_bits, half_bit}; // R5
   assign addr_hit = (shift_r[7:1] == own_addr) || (shift_r[7:1] == BROADCAST_ADDR); // R5

   // delayed copies for edge and condition detection
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_d_r <= 1'b0;
         sda_d_r <= 1'b0;
      end
      else
      begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   assign scl_rise   = scl_s & ~scl_d_r;
   assign scl_fall   = ~scl_s & scl_d_r;
   assign start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_seen  = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign byte_done  = scl_fall && (bit_cnt_r == BITS_PER_BYTE);

   // protocol next state
   always_comb
   begin
      state_nxt = state_r;
      if (start_seen)
         state_nxt = ST_ADDR;
      else if (stop_seen)
         state_nxt = ST_IDLE;
      else
      begin
         case (state_r)
            ST_IDLE:
               state_nxt = ST_IDLE;
            ST_ADDR:
               if (byte_done)
                  state_nxt = addr_hit ? ST_ADDR_ACK : ST_IDLE; // R5
            ST_ADDR_ACK:
               if (scl_fall)
                  state_nxt = rw_r ? ST_RDATA : ST_CMD;
            ST_CMD:
               if (byte_done)
                  state_nxt = ST_CMD_ACK;
            ST_CMD_ACK:
               if (scl_fall)
                  state_nxt = ST_WDATA;
            ST_WDATA:
               if (byte_done)
                  state_nxt = ST_WDATA_ACK;
            ST_WDATA_ACK:
               if (scl_fall)
                  state_nxt = ST_WDATA;
            ST_RDATA:
               if (byte_done)
                  state_nxt = ST_RDATA_ACK;
            ST_RDATA_ACK:
               if (scl_fall)
                  state_nxt = mack_r ? ST_IDLE : ST_RDATA;
            default:
               state_nxt = ST_IDLE;
         endcase
      end
   end

   // protocol state
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // bit counter, cleared at conditions and at each ninth clock
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         bit_cnt_r <= 4'h0;
      else if (start_seen || stop_seen)
         bit_cnt_r <= 4'h0;
      else if (byte_done || (scl_fall && (state_r == ST_ADDR_ACK || state_r == ST_CMD_ACK ||
               state_r == ST_WDATA_ACK || state_r == ST_RDATA_ACK)))
         bit_cnt_r <= 4'h0;
      else if (scl_rise && state_r != ST_IDLE)
         bit_cnt_r <= bit_cnt_r + 4'h1;
   end

   // receive shifter and host acknowledge sample
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_r <= 8'h00;
         mack_r  <= 1'b1;
      end
      else if (scl_rise)
      begin
         shift_r <= {shift_r[6:0], sda_s};
         if (state_r == ST_RDATA_ACK)
            mack_r <= sda_s;
      end
   end

   // direction bit and command code capture
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rw_r  <= 1'b0;
         cmd_r <= 8'h00;
      end
      else if (byte_done && state_r == ST_ADDR)
         rw_r <= shift_r[0];
      else if (byte_done && state_r == ST_CMD)
         cmd_r <= shift_r;
   end

   // read data select, unknown codes read zero
   always_comb
   begin
      case (cmd_r)
         CMD_ADDR_STATUS:  read_byte = status_byte; // R1
         CMD_CHANNEL_MODE: read_byte = mode_r;      // R6
         default:          read_byte = 8'h00;
      endcase
   end

   // open-drain data drive: acknowledges and read bits
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sda_oe_r <= 1'b0;
         tx_r     <= 8'h00;
      end
      else if (start_seen || stop_seen)
         sda_oe_r <= 1'b0;
      else if (byte_done && state_r == ST_ADDR)
         sda_oe_r <= addr_hit;
      else if (byte_done && (state_r == ST_CMD || state_r == ST_WDATA))
         sda_oe_r <= 1'b1;
      else if (scl_fall && (state_r == ST_ADDR_ACK || state_r == ST_RDATA_ACK))
      begin
         if ((state_r == ST_ADDR_ACK && rw_r) || (state_r == ST_RDATA_ACK && !mack_r))
         begin
            tx_r     <= read_byte;
            sda_oe_r <= ~read_byte[7];
         end
         else
            sda_oe_r <= 1'b0;
      end
      else if (scl_fall && (state_r == ST_CMD_ACK || state_r == ST_WDATA_ACK))
         sda_oe_r <= 1'b0;
      else if (scl_fall && state_r == ST_RDATA)
      begin
         if (bit_cnt_r == BITS_PER_BYTE)
            sda_oe_r <= 1'b0;
         else
         begin
            sda_oe_r <= ~tx_r[6];
            tx_r     <= {tx_r[6:0], 1'b0};
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = sda_oe_r;

   // only the mode code takes data; status writes fall through
   assign mode_wr = byte_done && (state_r == ST_WDATA) && (cmd_r == CMD_CHANNEL_MODE); // R20

   // channel mode register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_r <= MODE_RESET; // R6
      else if (mode_wr)
         mode_r <= shift_r; // R7
   end

   assign channel_mode_select = mode_r;

   // per-channel off decode and off entry watchers
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_chan
         assign chan_off[ch] = (field_of(mode_r, ch) == MODE_OFF); // R7
         // write data that would take this channel from running to off
         assign off_going[ch] = (field_of(mode_r, ch) != MODE_OFF) &&
                                (field_of(shift_r, ch) == MODE_OFF); // R16
         off_entry_watch u_watch (
            .sys_clk        (sys_clk),
            .rst_n          (rst_n),
            .mode_field     (field_of(mode_r, ch)),
            .power_good     (power_good_status[ch]),
            .power_enabled  (power_enabled_status[ch]),
            .off_clear      (channel_off_clear[ch]),
            .pg_event       (power_good_change_event[ch]),
            .pe_event       (power_enable_change_event[ch]),
            .cooldown_abort (cooldown_abort[ch])
         );
      end
   endgenerate

   // ports pair channels 1-2 and 3-4
   assign mismatch[0] = field_of(mode_r, 0) != field_of(mode_r, 1); // R8
   assign mismatch[1] = field_of(mode_r, 2) != field_of(mode_r, 3); // R8

   // grants toward the channel engines
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         detect_grant    <= 4'h0;
         classify_grant  <= 4'h0;
         power_on_grant  <= 4'h0;
         turn_on_blocked <= 2'h0;
      end
      else
      begin
         detect_grant    <= detect_request & ~chan_off;   // R9
         classify_grant  <= classify_request & ~chan_off; // R9
         power_on_grant  <= power_on_command & ~chan_off &
                            ~{mismatch[1], mismatch[1], mismatch[0], mismatch[0]}; // R8 R9
         turn_on_blocked <= mismatch; // R8
      end
   end

   // port-level clear for the four-pair policing byte
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         port_off_clear <= 2'h0;
      else
      begin
         port_off_clear[0] <= channel_off_clear[0] | channel_off_clear[1]; // R12
         port_off_clear[1] <= channel_off_clear[2] | channel_off_clear[3]; // R12
      end
   end

   // helper: cycles from an off write to its clear strobe
   logic [31:0] clear_wait_r;
   logic        clear_pending_r;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clear_pending_r <= 1'b0;
         clear_wait_r    <= 32'h0;
      end
      else if (|channel_off_clear)
      begin
         clear_pending_r <= 1'b0;
         clear_wait_r    <= 32'h0;
      end
      else if (mode_wr && (|off_going))
         clear_pending_r <= 1'b1;
      else if (clear_pending_r)
         clear_wait_r <= clear_wait_r + 32'h1;
   end

   property p_clear_bound;
      @(posedge sys_clk) disable iff (!rst_n)
      clear_wait_r <= 32'(OFF_CLEAR_LIMIT);
   endproperty
   a_clear_bound: assert property (p_clear_bound) // R16
      else $error("off clearing took too long");

   sequence s_addr_byte;
      (state_r == ST_ADDR) && byte_done;
   endsequence

   property p_addr_refuse;
      @(posedge sys_clk) disable iff (!rst_n)
      s_addr_byte ##0 !addr_hit && !start_seen && !stop_seen |=> (state_r == ST_IDLE) && !sda_oe;
   endproperty
   a_addr_refuse: assert property (p_addr_refuse) // R5
      else $error("foreign address acknowledged");

   property p_broadcast_ack;
      @(posedge sys_clk) disable iff (!rst_n)
      s_addr_byte ##0 (shift_r[7:1] == BROADCAST_ADDR) && !start_seen && !stop_seen
         |=> sda_oe && (state_r == ST_ADDR_ACK);
   endproperty
   a_broadcast_ack: assert property (p_broadcast_ack) // R5
      else $error("broadcast address not acknowledged");

   property p_status_read;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_r == ST_ADDR_ACK) && scl_fall && rw_r && (cmd_r == CMD_ADDR_STATUS) &&
         !start_seen && !stop_seen |=> tx_r == {1'b0, $past(strap_address_bits),
         $past(half_bit), 2'b00};
   endproperty
   a_status_read: assert property (p_status_read) // R1
      else $error("status read byte has wrong layout");

   property p_half_cfg_b;
      @(posedge sys_clk) disable iff (!rst_n)
      config_b_select |-> !status_byte[STATUS_HALF_BIT] && !own_addr[0];
   endproperty
   a_half_cfg_b: assert property (p_half_cfg_b) // R4
      else $error("half select bit not zero in configuration B");

   property p_mode_write;
      @(posedge sys_clk) disable iff (!rst_n)
      mode_wr |=> channel_mode_select == $past(shift_r);
   endproperty
   a_mode_write: assert property (p_mode_write) // R6
      else $error("mode register did not take written byte");

   property p_status_no_write;
      @(posedge sys_clk) disable iff (!rst_n)
      byte_done && (state_r == ST_WDATA) && (cmd_r != CMD_CHANNEL_MODE) |=> $stable(mode_r);
   endproperty
   a_status_no_write: assert property (p_status_no_write) // R20
      else $error("write to another code changed the mode register");

   property p_mismatch_block;
      @(posedge sys_clk) disable iff (!rst_n)
      mismatch[0] |=> (power_on_grant[1:0] == 2'h0) && turn_on_blocked[0];
   endproperty
   a_mismatch_block: assert property (p_mismatch_block) // R8
      else $error("turn-on granted on a mismatched port");

   property p_off_no_grant;
      @(posedge sys_clk) disable iff (!rst_n)
      chan_off[3] |=> !detect_grant[3] && !classify_grant[3] && !power_on_grant[3];
   endproperty
   a_off_no_grant: assert property (p_off_no_grant) // R9
      else $error("off channel granted an operation");

   property p_port_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      channel_off_clear[2] |=> port_off_clear[1] &&
         (!port_off_clear[0] || $past(|channel_off_clear[1:0]));
   endproperty
   a_port_clear: assert property (p_port_clear) // R12
      else $error("port clear missing or spilled to other port");

endmodule : pse_channel_mode_control

/* File: verification/i2c_host_model.sv */
// serial bus controller model for the management bus
`timescale 1ns/10ps
module i2c_host_model
(
   input  wire logic sys_clk,
   input  wire logic sda_wire,
   output logic      scl_out,
   output logic      sda_pull
);
   // bus idle, line released
   initial
   begin
      scl_out = 1'b1;
      sda_pull = 1'b0;
   end
   // wait falling clock edges
   task automatic gap(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : gap
   // start or repeated start
   task automatic start();
      sda_pull = 1'b0;
      gap(10);
      scl_out = 1'b1;
      gap(10);
      sda_pull = 1'b1;
      gap(10);
      scl_out = 1'b0;
   endtask : start
   // stop condition
   task automatic stop();
      sda_pull = 1'b1;
      gap(10);
      scl_out = 1'b1;
      gap(10);
      sda_pull = 1'b0;
      gap(10);
   endtask : stop
   // nine bits msb first, a one releases the line
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         gap(10);
         sda_pull = ~tx[i];
         gap(10);
         scl_out = 1'b1;
         gap(10);
         rx[i] = sda_wire;
         scl_out = 1'b0;
      end
   endtask : xfer
endmodule : i2c_host_model

/* File: verification/testbench.sv */
// bench for the channel mode control block
`timescale 1ns/10ps
`define CHK(a, b) cmp_count++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h want %h", $time, a, b); end
module testbench;
   import pse_mode_pkg::*;
   logic        sys_clk, rst_n, scl, sda_pull, sda_oe, sda_o, sda_wire, half, cfg_b, seen_reset;
   logic [3:0]  straps, req, pwr_cmd, pg_st, det_gnt, pwr_gnt, clr, pg_ev, pe_ev, cd_ab;
   logic [3:0]  cls_gnt, pe_st;
   logic [1:0]  blocked, port_clr;
   logic [7:0]  modes, rd_val;
   logic [8:0]  rx;
   logic [17:0] seen;
   logic [6:0]  dev;
   int          fails, cmp_count, cycles;
   // open-drain line with pull-up
   assign sda_wire = ~((sda_oe & ~sda_o) | sda_pull);
   assign dev = {2'b01, straps, half & ~cfg_b};
   i2c_host_model host_inst (.sys_clk, .sda_wire, .scl_out(scl), .sda_pull);
   pse_channel_mode_control #(.OFF_CLEAR_LIMIT(16)) pse_channel_mode_control_inst (
      .sys_clk, .rst_n, .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o), .sda_oe,
      .address_strap_pin_3(straps[3]), .address_strap_pin_2(straps[2]),
      .address_strap_pin_1(straps[1]), .address_strap_pin_0(straps[0]),
      .half_select_address_bit(half), .config_b_select(cfg_b),
      .detect_request(req), .classify_request(req), .power_on_command(pwr_cmd),
      .power_good_status(pg_st), .power_enabled_status(pe_st),
      .channel_mode_select(modes), .detect_grant(det_gnt), .classify_grant(cls_gnt),
      .power_on_grant(pwr_gnt), .turn_on_blocked(blocked), .channel_off_clear(clr),
      .port_off_clear(port_clr), .power_good_change_event(pg_ev),
      .power_enable_change_event(pe_ev), .cooldown_abort(cd_ab));
   // clock
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // collect one-cycle side-effect pulses
   always @(posedge sys_clk)
      seen <= seen_reset ? '0 : seen | {cd_ab, pe_ev, pg_ev, port_clr, clr};
   // hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         close_out();
      end
   end
   // counts and verdict
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // register write, checks address ack
   task automatic wr(input logic [6:0] a, input logic [7:0] c, d, input logic ak);
      host_inst.start();
      host_inst.xfer({a, 2'b01}, rx);
      `CHK(rx[0], ak)
      host_inst.xfer({c, 1'b1}, rx);
      host_inst.xfer({d, 1'b1}, rx);
      host_inst.stop();
   endtask : wr
   // register read with repeated start
   task automatic rd(input logic [7:0] c);
      host_inst.start();
      host_inst.xfer({dev, 2'b01}, rx);
      host_inst.xfer({c, 1'b1}, rx);
      host_inst.start();
      host_inst.xfer({dev, 2'b11}, rx);
      host_inst.xfer(9'h1ff, rx);
      rd_val = rx[8:1];
      host_inst.stop();
   endtask : rd
   // main sequence
   initial
   begin
      fails = 0;
      cmp_count = 0;
      cycles = 0;
      rst_n = 1'b0;
      straps = 4'ha;
      half = 1'b1;
      cfg_b = 1'b0;
      req = 4'hf;
      pwr_cmd = 4'hf;
      pg_st = 4'h7;
      pe_st = 4'hd;
      seen_reset = 1'b1;
      repeat (6) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      `CHK(modes, MODE_RESET)
      rd(CMD_ADDR_STATUS);
      `CHK(rd_val, 8'h54)
      cfg_b = 1'b1;
      rd(CMD_ADDR_STATUS);
      `CHK(rd_val, 8'h50)
      wr(BROADCAST_ADDR, CMD_ADDR_STATUS, 8'hff, 1'b0);
      rd(CMD_ADDR_STATUS);
      `CHK(rd_val, 8'h50)
      wr(dev ^ 7'h01, CMD_CHANNEL_MODE, 8'hff, 1'b1);
      wr(BROADCAST_ADDR, CMD_CHANNEL_MODE, 8'he4, 1'b0);
      rd(CMD_CHANNEL_MODE);
      `CHK(rd_val, 8'he4)
      rd(8'h13);
      `CHK(rd_val, 8'h00)
      `CHK(blocked, 2'b11)
      `CHK(pwr_gnt, 4'h0)
      `CHK(det_gnt, 4'he)
      `CHK(cls_gnt, 4'he)
      // both ports with matching modes
      wr(dev, CMD_CHANNEL_MODE, 8'haf, 1'b0);
      `CHK({blocked, pwr_gnt}, 6'h0f)
      seen_reset = 1'b0;
      wr(dev, CMD_CHANNEL_MODE, 8'h2f, 1'b0);
      `CHK(modes, 8'h2f)
      `CHK(det_gnt, 4'h7)
      `CHK(seen, {4'h8, 4'h8, 4'h0, 2'b10, 4'h8})
      `CHK(cls_gnt, 4'h7)
      seen_reset = 1'b1;
      @(negedge sys_clk);
      seen_reset = 1'b0;
      // channel 3 semiauto to manual, channel 2 auto to off
      wr(dev, CMD_CHANNEL_MODE, 8'h13, 1'b0);
      `CHK(seen, {4'h4, 4'h0, 4'h2, 2'b01, 4'h2})
      `CHK({blocked, det_gnt, cls_gnt}, 10'h355)
      close_out();
   end
endmodule : testbench
